// ### pkg/lpddr_cmd_pkg.sv
package lpddr_cmd_pkg;
    typedef enum logic [2:0] {
        BANK_IDLE    = 3'b001,
        BANK_OPEN    = 3'b010,
        BANK_CLOSING = 3'b100
    } bank_state_t;
    typedef enum logic [2:0] {
        CMD_MRS = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR  = 3'b100,
        CMD_RD  = 3'b101,
        CMD_BST = 3'b110,
        CMD_NOP = 3'b111
    } cmd_t;
endpackage

// ### pkg/lpddr_map.svh
`ifndef LPDDR_MAP_SVH
`define LPDDR_MAP_SVH
`define SYS_CLK_MHZ    125
`define ROW_CLOSE_NS   20
`define ROW_CLOSE_CYC  ((`ROW_CLOSE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define REG_STATUS     8'h00
`define REG_MODE       8'h04
`define REG_EXT_MODE   8'h08
`define REG_CTRL       8'h0c
`define REG_ERR        8'h10
`define CTRL_EN_BIT    0
`define CTRL_RST       1'b1
`define ERR_ILL_BIT    0
`define ERR_LOST_LSB   4
`define MR_RST         12'h000
`define EMR_RST        12'h000
`define MR_BL_MSB      2
`define MR_BT_BIT      3
`define EMR_PARTIAL_REFRESH_EXTENT_MSB   2
`define EMR_DS_LSB     5
`define EMR_DS_MSB     6
`define ADDR_AP_BIT    10
`define PARTIAL_REFRESH_EXTENT_HALF      3'h1
`define PARTIAL_REFRESH_EXTENT_QUARTER   3'h2
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define PIN_IDLE       37'h1e_0000_0000
`endif

// ### rtl/lpddr_command_decode_bank_ctl.sv
`timescale 1ns/1ps
`include "lpddr_map.svh"
module lpddr_command_decode_bank_ctl
    import lpddr_cmd_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic        mem_cs_n_in,
    input  wire logic        mem_ras_n_in,
    input  wire logic        mem_cas_n_in,
    input  wire logic        mem_we_n_in,
    input  wire logic        bank_select_lsb_in,
    input  wire logic        bank_select_msb_in,
    input  wire logic [11:0] mem_addr_in,
    input  wire logic        mem_cke_in,
    input  wire logic [1:0]  byte_write_mask_in,
    input  wire logic [15:0] mem_dq_in,
    output logic             wr_valid_out,
    output logic [1:0]       wr_byte_en_out,
    output logic [15:0]      wr_data_out,
    output logic             rd_valid_out,
    output logic [1:0]       acc_bank_out,
    output logic [8:0]       acc_col_out,
    output logic [11:0]      acc_row_out,
    output logic             auto_refresh_out,
    output logic             self_refresh_out,
    output logic [3:0]       refresh_bank_en_out,
    output logic [1:0]       drive_sel_out,
    output logic [3:0]       bank_open_out,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in
);
    localparam int PW = 37;
    logic [PW-1:0] pin_meta, pin_sync;
    // pins pass two flops before decode
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_meta <= `PIN_IDLE;
            pin_sync <= `PIN_IDLE;
        end else if (clk_en_in) begin
            pin_meta <= {mem_cs_n_in, mem_ras_n_in, mem_cas_n_in, mem_we_n_in,
                         bank_select_msb_in, bank_select_lsb_in, mem_addr_in,
                         mem_cke_in, byte_write_mask_in, mem_dq_in};
            pin_sync <= pin_meta;
        end
    end

    logic        cmd_cs_n, cke;
    cmd_t        cmd;
    logic [1:0]  cmd_ba, dm, addr_drv;
    logic [11:0] cmd_addr;
    logic [15:0] dq;
    assign cmd_cs_n = pin_sync[36];
    assign cmd      = cmd_t'(pin_sync[35:33]);
    assign cmd_ba   = pin_sync[32:31];
    assign cmd_addr = pin_sync[30:19];
    assign cke      = pin_sync[18];
    assign dm       = pin_sync[17:16];
    assign dq       = pin_sync[15:0];
    assign addr_drv = cmd_addr[`EMR_DS_MSB:`EMR_DS_LSB];

    bank_state_t bank_st [4];
    bank_state_t next_bank_st [4];
    logic [11:0] open_row [4];
    logic [11:0] next_open_row [4];
    logic [3:0]  close_cnt [4];
    logic [3:0]  next_close_cnt [4];
    logic [11:0] mr, next_mr, emr, next_emr;
    logic        ctrl_en, next_ctrl_en, err_ill, next_err_ill, sr, next_sr;
    logic [3:0]  lost, next_lost, next_rf_en, partial_refresh_extent_mask, closing_vec;
    logic        burst_on, next_burst_on, burst_wr, next_burst_wr;
    logic        burst_ap, next_burst_ap;
    logic [1:0]  burst_bank, next_burst_bank;
    logic [8:0]  burst_start, next_burst_start, burst_col;
    logic [2:0]  burst_idx, next_burst_idx, bmask, col_low;
    logic [3:0]  beats;
    logic        burst_last;
    logic        next_wr_valid, next_rd_valid, next_auto_ref;
    logic [1:0]  next_wr_be, next_acc_bank;
    logic [15:0] next_wr_data;
    logic [8:0]  next_acc_col;
    logic [11:0] next_acc_row;
    logic        sel, cmd_exec, enter_sr, act_ok, mr_load, emr_load;
    logic        pre_all, pre_one, sw_wr;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // decode with select low, gated by the software enable
    assign sel      = !cmd_cs_n && ctrl_en;
    assign cmd_exec = !sr && sel && cke;
    assign enter_sr = !sr && sel && !cke && cmd == CMD_REF;
    assign act_ok   = cmd_exec && cmd == CMD_ACT && bank_st[cmd_ba] == BANK_IDLE;
    assign mr_load  = cmd_exec && cmd == CMD_MRS && cmd_ba == 2'b00;
    assign emr_load = cmd_exec && cmd == CMD_MRS && cmd_ba == 2'b01;
    assign pre_all  = cmd_exec && cmd == CMD_PRE && cmd_addr[`ADDR_AP_BIT];
    assign pre_one  = cmd_exec && cmd == CMD_PRE && !cmd_addr[`ADDR_AP_BIT];
    // only the partial-array bits shape the mask; temperature bits unread
    assign partial_refresh_extent_mask = (emr[`EMR_PARTIAL_REFRESH_EXTENT_MSB:0] == `PARTIAL_REFRESH_EXTENT_HALF)    ? 4'h3 :
                       (emr[`EMR_PARTIAL_REFRESH_EXTENT_MSB:0] == `PARTIAL_REFRESH_EXTENT_QUARTER) ? 4'h1 : 4'hf;
    assign drive_sel_out = emr[`EMR_DS_MSB:`EMR_DS_LSB];

    // burst length, then sequential or interleaved column walk
    assign beats = (mr[`MR_BL_MSB:0] == 3'h3) ? 4'h8 :
                   (mr[`MR_BL_MSB:0] == 3'h2) ? 4'h4 : 4'h2;
    assign bmask = 3'(beats - 4'h1);
    assign col_low = mr[`MR_BT_BIT] ? (burst_start[2:0] ^ burst_idx)
                                    : 3'(burst_start[2:0] + burst_idx);
    assign burst_col = {burst_start[8:3], (burst_start[2:0] & ~bmask) | (col_low & bmask)};
    assign burst_last = burst_idx == bmask;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            next_bank_st[b]   = bank_st[b];
            next_open_row[b]  = open_row[b];
            next_close_cnt[b] = close_cnt[b];
            if (bank_st[b] == BANK_CLOSING) begin
                if (close_cnt[b] <= 4'h1) begin
                    next_bank_st[b] = BANK_IDLE;
                end else begin
                    next_close_cnt[b] = close_cnt[b] - 4'h1;
                end
            end
        end
        next_mr = mr;
        next_emr = emr;
        next_ctrl_en = ctrl_en;
        next_err_ill = err_ill;
        next_lost = lost;
        next_sr = sr;
        next_burst_on = burst_on;
        next_burst_wr = burst_wr;
        next_burst_ap = burst_ap;
        next_burst_bank = burst_bank;
        next_burst_start = burst_start;
        next_burst_idx = burst_idx;
        next_wr_valid = 1'b0;
        next_rd_valid = 1'b0;
        next_auto_ref = 1'b0;
        next_wr_be = wr_byte_en_out;
        next_wr_data = wr_data_out;
        next_acc_bank = acc_bank_out;
        next_acc_col = acc_col_out;
        next_acc_row = acc_row_out;
        // software clears first so hardware events win
        if (sw_wr && w_strb[0] && aw_addr == `REG_CTRL) begin
            next_ctrl_en = w_data[`CTRL_EN_BIT];
        end
        if (sw_wr && w_strb[0] && aw_addr == `REG_ERR) begin
            next_err_ill = err_ill & ~w_data[`ERR_ILL_BIT];
            next_lost = lost & ~w_data[`ERR_LOST_LSB+3:`ERR_LOST_LSB];
        end
        if (burst_on) begin
            next_acc_bank = burst_bank;
            next_acc_col = burst_col;
            next_acc_row = open_row[burst_bank];
            if (burst_wr) begin
                next_wr_valid = 1'b1;
                next_wr_be = ~dm;
                next_wr_data = dq;
            end else begin
                next_rd_valid = 1'b1;
            end
            next_burst_idx = burst_idx + 3'h1;
            if (burst_last) begin
                next_burst_on = 1'b0;
                if (burst_ap) begin
                    next_bank_st[burst_bank] = BANK_CLOSING;
                    next_close_cnt[burst_bank] = 4'(`ROW_CLOSE_CYC);
                end
            end
        end
        if (sr) begin
            if (cke) begin
                next_sr = 1'b0;
            end
        end else if (enter_sr) begin
            next_sr = 1'b1;
            next_burst_on = 1'b0;
            next_lost = next_lost | ~partial_refresh_extent_mask;
        end else if (sel && !cke) begin
            next_err_ill = 1'b1;
        end else if (sel) begin
            unique case (cmd)
                CMD_NOP: begin
                end
                CMD_ACT: begin
                    if (act_ok) begin
                        next_bank_st[cmd_ba] = BANK_OPEN;
                        next_open_row[cmd_ba] = cmd_addr;
                    end else begin
                        next_err_ill = 1'b1;
                    end
                end
                CMD_RD, CMD_WR: begin
                    if (bank_st[cmd_ba] == BANK_OPEN) begin
                        next_burst_on = 1'b1;
                        next_burst_wr = cmd == CMD_WR;
                        next_burst_ap = cmd_addr[`ADDR_AP_BIT];
                        next_burst_bank = cmd_ba;
                        next_burst_start = cmd_addr[8:0];
                        next_burst_idx = 3'h0;
                    end else begin
                        next_err_ill = 1'b1;
                    end
                end
                CMD_BST: begin
                    if (burst_on && !burst_wr && !burst_ap) begin
                        next_burst_on = 1'b0;
                    end
                end
                CMD_PRE: begin
                    for (int b = 0; b < 4; b++) begin
                        if (bank_st[b] == BANK_OPEN && (pre_all || cmd_ba == 2'(b))) begin
                            next_bank_st[b] = BANK_CLOSING;
                            next_close_cnt[b] = 4'(`ROW_CLOSE_CYC);
                        end
                    end
                end
                CMD_REF: begin
                    next_auto_ref = 1'b1;
                end
                CMD_MRS: begin
                    if (mr_load) begin
                        next_mr = cmd_addr;
                    end else if (emr_load) begin
                        next_emr = cmd_addr;
                    end
                    if (!mr_load && !emr_load || bank_open_out != 4'h0 || closing_vec != 4'h0) begin
                        next_err_ill = 1'b1;
                    end
                end
            endcase
        end
        next_rf_en = next_sr ? partial_refresh_extent_mask : 4'hf;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            for (int b = 0; b < 4; b++) begin
                bank_st[b] <= BANK_IDLE;
                open_row[b] <= 12'h000;
                close_cnt[b] <= 4'h0;
            end
            mr <= `MR_RST;
            emr <= `EMR_RST;
            ctrl_en <= `CTRL_RST;
            err_ill <= 1'b0;
            lost <= 4'h0;
            sr <= 1'b0;
            burst_on <= 1'b0;
            burst_wr <= 1'b0;
            burst_ap <= 1'b0;
            burst_bank <= 2'h0;
            burst_start <= 9'h000;
            burst_idx <= 3'h0;
            wr_valid_out <= 1'b0;
            wr_byte_en_out <= 2'h0;
            wr_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
            acc_bank_out <= 2'h0;
            acc_col_out <= 9'h000;
            acc_row_out <= 12'h000;
            auto_refresh_out <= 1'b0;
            refresh_bank_en_out <= 4'hf;
        end else if (clk_en_in) begin
            bank_st <= next_bank_st;
            open_row <= next_open_row;
            close_cnt <= next_close_cnt;
            mr <= next_mr;
            emr <= next_emr;
            ctrl_en <= next_ctrl_en;
            err_ill <= next_err_ill;
            lost <= next_lost;
            sr <= next_sr;
            burst_on <= next_burst_on;
            burst_wr <= next_burst_wr;
            burst_ap <= next_burst_ap;
            burst_bank <= next_burst_bank;
            burst_start <= next_burst_start;
            burst_idx <= next_burst_idx;
            wr_valid_out <= next_wr_valid;
            wr_byte_en_out <= next_wr_be;
            wr_data_out <= next_wr_data;
            rd_valid_out <= next_rd_valid;
            acc_bank_out <= next_acc_bank;
            acc_col_out <= next_acc_col;
            acc_row_out <= next_acc_row;
            auto_refresh_out <= next_auto_ref;
            refresh_bank_en_out <= next_rf_en;
        end
    end

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bank_open_out[b] = bank_st[b] == BANK_OPEN;
            closing_vec[b] = bank_st[b] == BANK_CLOSING;
        end
    end
    assign self_refresh_out = sr;

    // register bus slave
    logic        aw_hold, next_aw_hold, w_hold, next_w_hold, next_bvalid, next_rvalid;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_w_data, next_rdata;
    logic [3:0]  next_w_strb;
    logic [1:0]  next_bresp, next_rresp;
    assign s_axi_awready_out = !aw_hold;
    assign s_axi_wready_out  = !w_hold;
    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign sw_wr = aw_hold && w_hold && !s_axi_bvalid_out;

    always_comb begin
        next_aw_hold = aw_hold;
        next_aw_addr = aw_addr;
        next_w_hold = w_hold;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid_out;
        next_bresp = s_axi_bresp_out;
        next_rvalid = s_axi_rvalid_out;
        next_rdata = s_axi_rdata_out;
        next_rresp = s_axi_rresp_out;
        if (s_axi_awvalid_in && !aw_hold) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_hold) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
        if (sw_wr) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr <= `REG_ERR && aw_addr[1:0] == 2'b00) ? `RESP_OKAY
                                                                        : `RESP_SLVERR;
        end
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
            next_rvalid = 1'b1;
            next_rresp = `RESP_OKAY;
            unique case (s_axi_araddr_in)
                `REG_STATUS:   next_rdata = {22'h0, burst_on, sr, closing_vec, bank_open_out};
                `REG_MODE:     next_rdata = {20'h0, mr};
                `REG_EXT_MODE: next_rdata = {20'h0, emr};
                `REG_CTRL:     next_rdata = {31'h0, ctrl_en};
                `REG_ERR:      next_rdata = {24'h0, lost, 3'h0, err_ill};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            aw_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_hold <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `RESP_OKAY;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `RESP_OKAY;
        end else if (clk_en_in) begin
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold <= next_w_hold;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid_out <= next_bvalid;
            s_axi_bresp_out <= next_bresp;
            s_axi_rvalid_out <= next_rvalid;
            s_axi_rdata_out <= next_rdata;
            s_axi_rresp_out <= next_rresp;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_ap_last;
        clk_en_in && burst_on && burst_last && burst_ap;
    endsequence
    sequence s_sr_entry;
        clk_en_in && enter_sr;
    endsequence
    property p_partial_refresh_extent;
        s_sr_entry |=> self_refresh_out && refresh_bank_en_out == $past(partial_refresh_extent_mask);
    endproperty
    a_partial_refresh_extent: assert property (p_partial_refresh_extent) else $error("refresh banks wrong");
    property p_lost;
        s_sr_entry |=> (lost | $past(partial_refresh_extent_mask)) == 4'hf;
    endproperty
    a_lost: assert property (p_lost) else $error("lost flag missing");
    property p_drive;
        clk_en_in && emr_load |=> drive_sel_out == $past(addr_drv);
    endproperty
    a_drive: assert property (p_drive) else $error("drive select wrong");
    property p_mr;
        clk_en_in && mr_load |=> mr == $past(cmd_addr);
    endproperty
    a_mr: assert property (p_mr) else $error("mode load wrong");
    property p_act;
        clk_en_in && act_ok |=> bank_open_out[$past(cmd_ba)]
                                && open_row[$past(cmd_ba)] == $past(cmd_addr);
    endproperty
    a_act: assert property (p_act) else $error("row not opened");
    property p_pre_all;
        clk_en_in && pre_all |=> bank_open_out == 4'h0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("bank left open");
    property p_idle_pre;
        clk_en_in && pre_one && bank_st[cmd_ba] == BANK_IDLE
            |=> bank_st[$past(cmd_ba)] == BANK_IDLE;
    endproperty
    a_idle_pre: assert property (p_idle_pre) else $error("idle precharge acted");
    property p_mask;
        clk_en_in && burst_on && burst_wr |=> wr_valid_out && wr_byte_en_out == ~$past(dm);
    endproperty
    a_mask: assert property (p_mask) else $error("write mask wrong");
    property p_auto_close;
        s_ap_last |=> bank_st[$past(burst_bank)] == BANK_CLOSING;
    endproperty
    a_auto_close: assert property (p_auto_close) else $error("no auto close");
    property p_desel;
        clk_en_in && cmd_cs_n && !burst_on |=> bank_open_out == $past(bank_open_out);
    endproperty
    a_desel: assert property (p_desel) else $error("deselect changed banks");
    property p_close_wait;
        clk_en_in && bank_st[0] == BANK_CLOSING && close_cnt[0] > 4'h1
            |=> bank_st[0] == BANK_CLOSING;
    endproperty
    a_close_wait: assert property (p_close_wait) else $error("bank idle too soon");
endmodule // lpddr_command_decode_bank_ctl

// ### sim/lpddr_command_decode_bank_ctl_tb_top.sv
`timescale 1ns/1ps
module lpddr_command_decode_bank_ctl_tb_top
    import lpddr_cmd_pkg::*;
;
    logic        clk = 0, rst_n = 0, go = 0, cke = 1, awv = 0, wv = 0, arv = 0, rry = 0, bry = 0;
    cmd_t        cmd = CMD_NOP;
    logic [1:0]  bk = 0, msk = 0, r, b;
    logic [11:0] ad = 0;
    logic [15:0] dq = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, d, seed = 32'he8de;
    logic        dsel = 0, il = 0;
    logic [8:0]  sc = 0;
    logic [11:0] rw = 0;
    wire  [2:0]  sn;
    wire  [1:0]  bp, br, rr, wbe, ds, ab;
    wire  [8:0]  ac;
    wire  [11:0] ap, arw;
    wire  [31:0] rd;
    wire  [3:0]  rbe, bo;
    wire  [15:0] wdo;
    wire         ckp, awr, wr, bv, arr, rv, wvo, rvo, sro, arf;
    int          err_total = 0, cmp_count = 0, wb = 0, rb = 0, bi = 0, bl = 4, nrf = 0;
    always #4 clk = ~clk;
    lpddr_ctl_model u_ctl (.go_in(go), .cmd_in(cmd), .bank_in(bk), .addr_in(ad), .cke_in(cke),
        .strobe_n_out(sn), .bank_out(bp), .addr_out(ap), .cke_out(ckp));
    lpddr_command_decode_bank_ctl u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
        .mem_cs_n_in(dsel), .mem_ras_n_in(sn[2]), .mem_cas_n_in(sn[1]), .mem_we_n_in(sn[0]),
        .bank_select_lsb_in(bp[0]), .bank_select_msb_in(bp[1]), .mem_addr_in(ap),
        .mem_cke_in(ckp), .byte_write_mask_in(msk), .mem_dq_in(dq), .wr_valid_out(wvo),
        .wr_byte_en_out(wbe), .wr_data_out(wdo), .rd_valid_out(rvo), .acc_bank_out(ab),
        .acc_col_out(ac), .acc_row_out(arw), .auto_refresh_out(arf), .self_refresh_out(sro),
        .refresh_bank_en_out(rbe), .drive_sel_out(ds), .bank_open_out(bo),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
        .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // column of beat i: wrap inside the burst block, or xor the start for interleaved
    function automatic logic [8:0] bcol(input logic [8:0] s, input int i);
        int m;
        m = bl - 1;
        return il ? (s ^ 9'(i)) : ((s & 9'(~m)) | 9'((s + i) & m));
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic axr(input logic [7:0] a);
        ara <= a; arv <= 1; rry <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        while (rv !== 1'b1) @(posedge clk);
        d = rd; r = rr; rry <= 0;
        @(posedge clk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw;
        ta = 0; tw = 0;
        awa <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
        do begin
            @(posedge clk);
            if (awr === 1'b1) begin ta = 1; awv <= 0; end
            if (wr === 1'b1) begin tw = 1; wv <= 0; end
        end while (!(ta && tw));
        do @(posedge clk); while (bv !== 1'b1);
        r = br; bry <= 0;
    endtask
    task automatic pulse(input cmd_t c, input logic [1:0] bb, input logic [11:0] a);
        @(posedge clk);
        cmd <= c; bk <= bb; ad <= a; go <= 1;
        @(posedge clk);
        go <= 0;
    endtask
    task automatic issue(input cmd_t c, input logic [1:0] bb, input logic [11:0] a);
        pulse(c, bb, a);
        repeat (10) @(posedge clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (wvo === 1'b1 || rvo === 1'b1) begin
            chk(ab, b);
            chk(ac, bcol(sc, bi));
            chk(arw, rw);
            bi++;
        end
        if (arf === 1'b1) nrf++;
        if (wvo === 1'b1) begin
            wb++;
            chk(wbe, 2'(~msk));
            chk(wdo, dq);
        end
        if (rvo === 1'b1) rb++;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk(bo, 4'h0);
        chk(rbe, 4'hf);
        axr(8'h0c); chk(d, 32'h1);
        axr(8'h14); chk(r, 2'h2);
        $display("reset and bus test done");
        seed = lfsr(seed);
        issue(CMD_MRS, 2'b00, 12'h002);
        axr(8'h04); chk(d, 32'h2);
        issue(CMD_MRS, 2'b01, {5'h0, seed[1:0], seed[3:2], 3'h1});
        chk(ds, seed[1:0]);
        $display("mode test done");
        b = seed[5:4];
        rw = seed[17:6];
        issue(CMD_ACT, b, rw);
        chk(bo, 4'h1 << b);
        issue(CMD_RD, b ^ 2'h1, 12'h000); chk(rb, 0);
        seed = lfsr(seed);
        msk <= seed[1:0]; dq <= seed[31:16];
        sc = 9'h005;
        bi = 0;
        issue(CMD_WR, b, 12'h005); chk(wb, 4);
        chk(bo, 4'h1 << b);
        sc = 9'h003;
        bi = 0;
        issue(CMD_RD, b, 12'h403); chk(rb, 4);
        chk(bo, 4'h0);
        $display("access test done");
        issue(CMD_ACT, 2'h0, 12'h011);
        issue(CMD_ACT, 2'h3, 12'h022);
        issue(CMD_PRE, 2'h0, 12'h000); chk(bo, 4'h8);
        issue(CMD_PRE, 2'h0, 12'h400); chk(bo, 4'h0);
        $display("precharge test done");
        issue(CMD_MRS, 2'b00, 12'h00b);
        b = 2'h2;
        rw = 12'h0a5;
        sc = 9'h005;
        bl = 8;
        il = 1;
        bi = 0;
        issue(CMD_ACT, b, rw);
        pulse(CMD_RD, b, 12'h005);
        pulse(CMD_BST, b, 12'h000);
        repeat (10) @(posedge clk);
        chk(rb, 6);
        chk(bo, 4'h4);
        dsel <= 1;
        issue(CMD_ACT, 2'h1, 12'h000);
        chk(bo, 4'h4);
        dsel <= 0;
        issue(CMD_REF, 2'h0, 12'h000);
        chk(nrf, 1);
        $display("truncate and refresh test done");
        cke <= 0;
        issue(CMD_REF, 2'h0, 12'h000);
        chk(sro, 1'b1);
        chk(rbe, 4'h3);
        cke <= 1;
        repeat (6) @(posedge clk);
        chk(sro, 1'b0);
        axr(8'h10); chk(d[7:4], 4'hc);
        axw(8'h10, 32'hf0); axr(8'h10); chk(d[7:4], 4'h0);
        $display("self refresh test done");
        test_done;
    end
endmodule // lpddr_command_decode_bank_ctl_tb_top

// ### sim/lpddr_ctl_model.sv
`timescale 1ns/1ps
module lpddr_ctl_model
    import lpddr_cmd_pkg::*;
(
    input  wire logic        go_in,
    input  wire cmd_t        cmd_in,
    input  wire logic [1:0]  bank_in,
    input  wire logic [11:0] addr_in,
    input  wire logic        cke_in,
    output logic [2:0]       strobe_n_out,
    output logic [1:0]       bank_out,
    output logic [11:0]      addr_out,
    output logic             cke_out
);
    // idle cycles carry a nop; unused lines toggle so stale values never look valid
    assign strobe_n_out = go_in ? cmd_in : CMD_NOP;
    assign bank_out     = go_in ? bank_in : ~bank_in;
    assign addr_out     = go_in ? addr_in : ~addr_in;
    assign cke_out      = cke_in;
endmodule // lpddr_ctl_model
